//--- src/brf_pkg.sv
// brf_pkg: constants shared by the banked register file and status word logic.
// assumes one core clock and a synchronous active-high reset.
package brf_pkg;
    // ----------------------------------------------------------------
    // data widths and register counts
    // ----------------------------------------------------------------
    localparam int XLEN      = 32;
    localparam int GPR_CNT   = 31;   // physical general registers
    localparam int SAVE_CNT  = 5;    // one saved copy per privileged mode
    localparam int LANE_W    = 8;
    localparam logic [3:0] R_FIQ_LO = 4'h8;
    localparam logic [3:0] R_SP     = 4'hD;
    localparam logic [3:0] R_LR     = 4'hE;
    localparam logic [3:0] R_PC     = 4'hF;
    // physical slots of the banked copies
    localparam logic [4:0] FIQ_BASE = 5'h10;
    localparam logic [4:0] SVC_BASE = 5'h17;
    localparam logic [4:0] ABT_BASE = 5'h19;
    localparam logic [4:0] IRQ_BASE = 5'h1B;
    localparam logic [4:0] UND_BASE = 5'h1D;
    // ----------------------------------------------------------------
    // mode codes and status word layout
    // ----------------------------------------------------------------
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1B;
    localparam logic [2:0] SP_FIQ = 3'h0;
    localparam logic [2:0] SP_SVC = 3'h1;
    localparam logic [2:0] SP_ABT = 3'h2;
    localparam logic [2:0] SP_IRQ = 3'h3;
    localparam logic [2:0] SP_UND = 3'h4;
    localparam int PSR_I = 7;
    localparam int PSR_F = 6;
    localparam int CTRL_BITS = 28;   // low control field, flags above
    localparam logic [31:0] PSR_RESET = 32'h000000D3;
    // ----------------------------------------------------------------
    // configuration port map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CFG    = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_SAVED  = 4'h8;
    localparam int CFG_W       = 4;
    localparam int CFG_BIGEND  = 0;
    localparam int CFG_LATEABT = 1;
    localparam int CFG_PROGW   = 2;
    localparam int CFG_DATAW   = 3;
    localparam logic [3:0] CFG_RESET = 4'hC;
endpackage

//--- src/brf_regfile.sv
// brf_regfile: mode-banked general registers, status words, byte lanes, abort select.
// assumes the core datapath drives requests synchronous to clk and never
// raises the config read and write strobes together.
// Operation
// - little-endian puts byte 0 on low lane
// - big-endian puts byte 0 on top lane
// - late abort only changes single transfers
// - bytes and aligned words only
// - 31 general plus 6 status registers
// - sixteen registers visible, 15 is PC
// - reading PC gives zero low bits
// - branch-link copies PC into banked R14
// - fast interrupt banks R8 to R14
// - other privileged modes bank R13, R14
// - exception saves status into mode copy
// - saved copy visible only when privileged
// - alu updates condition flags
// - mask bits block the two interrupts
// - control bits writable only when privileged
// - mode codes select the register bank
// - four config bits change while running
// - fast entry sets mode and both masks
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module brf_regfile (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  cfgAddr,
    input  wire logic [31:0] cfgWrData,
    input  wire logic        cfgWrEn,
    input  wire logic        cfgRdEn,
    output logic      [31:0] cfgRdData,
    input  wire logic [3:0]  rdSelA,
    input  wire logic [3:0]  rdSelB,
    output logic      [31:0] rdDataA,
    output logic      [31:0] rdDataB,
    input  wire logic        wrEn,
    input  wire logic [3:0]  wrSel,
    input  wire logic [31:0] wrData,
    input  wire logic        pcWrEn,
    input  wire logic [31:0] pcNext,
    input  wire logic        linkEn,
    input  wire logic        aluFlagsEn,
    input  wire logic [3:0]  aluFlags,
    input  wire logic        psrWrEn,
    input  wire logic        psrWrSaved,
    input  wire logic        psrWrFlags,
    input  wire logic        psrWrCtrl,
    input  wire logic [31:0] psrWrData,
    input  wire logic        excEn,
    input  wire logic [4:0]  excMode,
    input  wire logic [31:0] excLink,
    input  wire logic        irqReq,
    input  wire logic        fiqReq,
    output logic             irqTake,
    output logic             fiqTake,
    output logic      [31:0] curStatus,
    output logic      [31:0] savedStatus,
    input  wire logic        memReq,
    input  wire logic        memByte,
    input  wire logic [1:0]  memAddrLo,
    input  wire logic [31:0] memStData,
    input  wire logic [31:0] memRdWord,
    output logic      [31:0] memWrWord,
    output logic      [3:0]  memLaneEn,
    output logic      [31:0] memLdData,
    output logic             alignFault,
    input  wire logic        dataAbort,
    input  wire logic        xferIsSingle,
    output logic             abortRollback,
    output logic             lateBaseWb,
    output logic             progSpaceWide,
    output logic             dataSpaceWide
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [31:0] gprQ [brf_pkg::GPR_CNT];
    logic [31:0] saveQ [brf_pkg::SAVE_CNT];
    logic [31:0] statQ;
    logic [brf_pkg::CFG_W-1:0] cfgQ;

    // map a visible register number to its physical slot for a mode
    function automatic logic [4:0] physIdx(input logic [4:0] m, input logic [3:0] r);
        logic [4:0] base;
        base = 5'h00;
        physIdx = {1'b0, r};
        case (m)
            brf_pkg::MODE_SVC: base = brf_pkg::SVC_BASE;
            brf_pkg::MODE_ABT: base = brf_pkg::ABT_BASE;
            brf_pkg::MODE_IRQ: base = brf_pkg::IRQ_BASE;
            brf_pkg::MODE_UND: base = brf_pkg::UND_BASE;
            default:           base = 5'h00;
        endcase
        if (m == brf_pkg::MODE_FIQ && r >= brf_pkg::R_FIQ_LO && r <= brf_pkg::R_LR) begin
            physIdx = 5'(brf_pkg::FIQ_BASE + (r - brf_pkg::R_FIQ_LO));
        end else if (base != 5'h00 && (r == brf_pkg::R_SP || r == brf_pkg::R_LR)) begin
            physIdx = 5'(base + (r - brf_pkg::R_SP));
        end
    endfunction

    // saved-copy slot of a mode; invalid codes fall back to user banking
    function automatic logic [3:0] spIdx(input logic [4:0] m);
        case (m)
            brf_pkg::MODE_FIQ: spIdx = {1'b1, brf_pkg::SP_FIQ};
            brf_pkg::MODE_SVC: spIdx = {1'b1, brf_pkg::SP_SVC};
            brf_pkg::MODE_ABT: spIdx = {1'b1, brf_pkg::SP_ABT};
            brf_pkg::MODE_IRQ: spIdx = {1'b1, brf_pkg::SP_IRQ};
            brf_pkg::MODE_UND: spIdx = {1'b1, brf_pkg::SP_UND};
            default:           spIdx = 4'h0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // bank selection and status decode
    // ----------------------------------------------------------------
    // mode comes from the registered word, so a mode write only moves the
    // bank from the following cycle on
    wire logic [4:0] curMode = statQ[4:0];
    wire logic [3:0] curSp   = spIdx(curMode);
    wire logic       curPriv = curSp[3];
    wire logic [3:0] excSp   = spIdx(excMode);
    wire logic [4:0] wrIdx   = physIdx(curMode, wrSel);
    wire logic [4:0] lrIdx   = physIdx(curMode, brf_pkg::R_LR);
    wire logic [4:0] excLrIdx = physIdx(excMode, brf_pkg::R_LR);
    wire logic [31:0] pcView = {gprQ[brf_pkg::R_PC][31:2], 2'b00};
    wire logic [31:0] rdA    = (rdSelA == brf_pkg::R_PC) ? pcView : gprQ[physIdx(curMode, rdSelA)];
    wire logic [31:0] rdB    = (rdSelB == brf_pkg::R_PC) ? pcView : gprQ[physIdx(curMode, rdSelB)];
    wire logic [31:0] curSaved = curPriv ? saveQ[curSp[2:0]] : 32'h00000000;

    // status word merge: flags always, control field only when privileged
    wire logic [31:0] fieldMask = {{(32-brf_pkg::CTRL_BITS){psrWrFlags}},
                                   {brf_pkg::CTRL_BITS{psrWrCtrl & curPriv}}};
    wire logic [31:0] psrSrc    = psrWrSaved ? curSaved : statQ;
    wire logic [31:0] psrMerged = (psrSrc & ~fieldMask) | (psrWrData & fieldMask);
    wire logic        setF      = (excMode == brf_pkg::MODE_FIQ);
    wire logic [31:0] excPsr    = {statQ[31:brf_pkg::PSR_I+1], 1'b1,
                                   statQ[brf_pkg::PSR_F] | setF,
                                   statQ[brf_pkg::PSR_F-1:5], excMode};
    wire logic [31:0] flagPsr   = {aluFlags, statQ[brf_pkg::CTRL_BITS-1:0]};
    wire logic        statWr    = psrWrEn & ~psrWrSaved;
    wire logic        saveWr    = psrWrEn & psrWrSaved & curPriv;
    wire logic [31:0] statD     = excEn ? excPsr :
                                  statWr ? psrMerged :
                                  aluFlagsEn ? flagPsr : statQ;

    // ----------------------------------------------------------------
    // general register writes
    // ----------------------------------------------------------------
    // later statements win: exception link over branch link over plain write
    always_ff @(posedge clk) begin
        if (wrEn) begin
            gprQ[wrIdx] <= wrData;
        end
        if (pcWrEn) begin
            gprQ[brf_pkg::R_PC] <= pcNext;
        end
        if (linkEn) begin
            gprQ[lrIdx] <= gprQ[brf_pkg::R_PC];
        end
        if (excEn) begin
            gprQ[excLrIdx] <= excLink;
        end
        if (sys_rst) begin
            gprQ[brf_pkg::R_PC] <= 32'h00000000;            // restart from zero
        end
    end

    // ----------------------------------------------------------------
    // status words
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            statQ <= brf_pkg::PSR_RESET;
        end else begin
            statQ <= statD;
        end
    end

    // entry saves the word as it stood before the exception
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < brf_pkg::SAVE_CNT; i++) begin
                saveQ[i] <= 32'h00000000;
            end
        end else if (excEn && excSp[3]) begin
            saveQ[excSp[2:0]] <= statQ;
        end else if (saveWr) begin
            saveQ[curSp[2:0]] <= psrMerged;
        end
    end

    // ----------------------------------------------------------------
    // configuration port
    // ----------------------------------------------------------------
    wire logic cfgHit = cfgWrEn && cfgAddr == brf_pkg::ADDR_CFG;
    wire logic [31:0] cfgRdMux =
        (cfgAddr == brf_pkg::ADDR_CFG)    ? {{(32-brf_pkg::CFG_W){1'b0}}, cfgQ} :
        (cfgAddr == brf_pkg::ADDR_STATUS) ? statQ :
        (cfgAddr == brf_pkg::ADDR_SAVED)  ? curSaved : 32'h00000000;
    wire logic bigEnd  = cfgQ[brf_pkg::CFG_BIGEND];
    wire logic lateAbt = cfgQ[brf_pkg::CFG_LATEABT];

    // bits take effect on the next access, no reset needed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfgQ      <= brf_pkg::CFG_RESET;
            cfgRdData <= 32'h00000000;
        end else begin
            if (cfgHit) begin
                cfgQ <= cfgWrData[brf_pkg::CFG_W-1:0];
            end
            cfgRdData <= cfgRdEn ? cfgRdMux : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // byte lanes, alignment and abort select
    // ----------------------------------------------------------------
    wire logic [1:0] lane = bigEnd ? ~memAddrLo : memAddrLo;
    wire logic [3:0] laneHot = 4'h1 << lane;
    wire logic [31:0] ldByte = {24'h000000, memRdWord[lane*brf_pkg::LANE_W +: brf_pkg::LANE_W]};
    // words must sit on four-byte boundaries; a misaligned word is flagged
    wire logic misAlign = memReq & ~memByte & (memAddrLo != 2'b00);
    wire logic single   = dataAbort & xferIsSingle;

    // lane outputs registered so they line up with the next bus phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            memWrWord     <= 32'h00000000;
            memLaneEn     <= 4'h0;
            memLdData     <= 32'h00000000;
            alignFault    <= 1'b0;
            abortRollback <= 1'b0;
            lateBaseWb    <= 1'b0;
        end else begin
            memWrWord     <= memByte ? {4{memStData[brf_pkg::LANE_W-1:0]}} : memStData;
            memLaneEn     <= !memReq ? 4'h0 : (memByte ? laneHot : 4'hF);
            memLdData     <= memByte ? ldByte : memRdWord;
            alignFault    <= misAlign;
            abortRollback <= single & ~lateAbt;
            lateBaseWb    <= single & lateAbt;
        end
    end

    // ----------------------------------------------------------------
    // operand reads, interrupt gating, status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdDataA     <= 32'h00000000;
            rdDataB     <= 32'h00000000;
            irqTake     <= 1'b0;
            fiqTake     <= 1'b0;
            savedStatus <= 32'h00000000;
        end else begin
            rdDataA     <= rdA;
            rdDataB     <= rdB;
            irqTake     <= irqReq & ~statQ[brf_pkg::PSR_I];
            fiqTake     <= fiqReq & ~statQ[brf_pkg::PSR_F];
            savedStatus <= curSaved;
        end
    end

    assign curStatus     = statQ;
    assign progSpaceWide = cfgQ[brf_pkg::CFG_PROGW];
    assign dataSpaceWide = cfgQ[brf_pkg::CFG_DATAW];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_le_lane;
        memReq && memByte && !bigEnd && memAddrLo == 2'b00 |=> memLaneEn == 4'h1;
    endproperty
    a_le_lane: assert property (p_le_lane) else $error("le byte0 lane wrong");

    property p_be_lane;
        memReq && memByte && bigEnd && memAddrLo == 2'b00 |=> memLaneEn == 4'h8;
    endproperty
    a_be_lane: assert property (p_be_lane) else $error("be byte0 lane wrong");

    property p_abort_other;
        dataAbort && !xferIsSingle |=> !abortRollback && !lateBaseWb;
    endproperty
    a_abort_other: assert property (p_abort_other) else $error("abort select leaked");

    property p_align;
        memReq && !memByte && memAddrLo != 2'b00 |=> alignFault;
    endproperty
    a_align: assert property (p_align) else $error("misaligned word missed");

    property p_pc_read;
        rdSelA == brf_pkg::R_PC |=> rdDataA == {$past(gprQ[brf_pkg::R_PC][31:2]), 2'b00};
    endproperty
    a_pc_read: assert property (p_pc_read) else $error("pc read wrong");

    property p_link;
        linkEn && !excEn
            |=> gprQ[$past(lrIdx)] == $past(gprQ[brf_pkg::R_PC]);
    endproperty
    a_link: assert property (p_link) else $error("link copy missing");

    property p_fiq_bank;
        wrEn && wrSel == brf_pkg::R_FIQ_LO && curMode == brf_pkg::MODE_FIQ
            |=> $stable(gprQ[brf_pkg::R_FIQ_LO]);
    endproperty
    a_fiq_bank: assert property (p_fiq_bank) else $error("fiq bank leak");

    property p_exc_save;
        excEn && excMode == brf_pkg::MODE_IRQ |=> saveQ[brf_pkg::SP_IRQ] == $past(statQ);
    endproperty
    a_exc_save: assert property (p_exc_save) else $error("status not saved");

    property p_irq_mask;
        statQ[brf_pkg::PSR_I] |=> !irqTake;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq taken");

    property p_user_ctrl;
        curMode == brf_pkg::MODE_USR && !excEn
            |=> statQ[brf_pkg::CTRL_BITS-1:0] == $past(statQ[brf_pkg::CTRL_BITS-1:0]);
    endproperty
    a_user_ctrl: assert property (p_user_ctrl) else $error("user changed control");

    property p_fiq_entry;
        excEn && excMode == brf_pkg::MODE_FIQ
            |=> curMode == brf_pkg::MODE_FIQ && statQ[brf_pkg::PSR_I] && statQ[brf_pkg::PSR_F];
    endproperty
    a_fiq_entry: assert property (p_fiq_entry) else $error("fiq entry wrong");

    property p_cfg_wr;
        cfgHit |=> cfgQ == $past(cfgWrData[brf_pkg::CFG_W-1:0]);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config not stored");

    c_fiq_entry: cover property (excEn && excMode == brf_pkg::MODE_FIQ);
    c_be_byte:   cover property (memReq && memByte && bigEnd);
    c_link_svc:  cover property (linkEn && curMode == brf_pkg::MODE_SVC);
endmodule

//--- tb/brf_seq_model.sv
// brf_seq_model: core-side stand-in that issues exception entries and answers
// memory reads. assumes the bench pulses excGo for exactly one cycle.
`timescale 1ns/10ps
module brf_seq_model (
    input  wire logic        clk,
    input  wire logic        excGo,
    input  wire logic [2:0]  excPick,
    input  wire logic [31:0] linkVal,
    input  wire logic        memReq,
    input  wire logic [31:0] fillWord,
    output logic             excEn,
    output logic      [4:0]  excMode,
    output logic      [31:0] excLink,
    output logic      [31:0] memRdWord
);
    logic [31:0] junkQ = 32'h5A5A5A5A;
    // ----------------------------------------------------------------
    // exception entry
    // ----------------------------------------------------------------
    // only the five privileged codes are ever issued, never a stray code
    assign excEn   = excGo;
    assign excLink = linkVal;
    always_comb begin
        case (excPick)
            3'h0:    excMode = brf_pkg::MODE_FIQ;
            3'h1:    excMode = brf_pkg::MODE_SVC;
            3'h2:    excMode = brf_pkg::MODE_ABT;
            3'h3:    excMode = brf_pkg::MODE_IRQ;
            default: excMode = brf_pkg::MODE_UND;
        endcase
    end
    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // off-request the bus churns so a stale capture cannot pass by luck
    always_ff @(posedge clk) begin
        junkQ <= junkQ + 32'h9E3779B9;
    end
    assign memRdWord = memReq ? fillWord : junkQ;
endmodule

//--- tb/test_brf_regfile.sv
// test_brf_regfile: self-checking bench, reference model with arrays.
// assumes brf_pkg is compiled first and brf_seq_model beside it.
`timescale 1ns/10ps
module test_brf_regfile;
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic [3:0]  cfgAddr, rdSelA, rdSelB, wrSel, aluFlags, memLaneEn, cfg;
    logic [31:0] cfgWrData, wrData, pcNext, psrWrData, memStData, fillWord, linkVal;
    logic [31:0] cfgRdData, rdDataA, rdDataB, curStatus, savedStatus, excLink;
    logic [31:0] memWrWord, memLdData, memRdWord, st, pc, d;
    logic [31:0] lf = 32'h0000003E;
    logic [31:0] rm [0:30];
    logic [31:0] sv [0:4];
    logic [4:0]  excMode;
    logic [2:0]  excPick;
    logic [1:0]  memAddrLo;
    logic        cfgWrEn, cfgRdEn, wrEn, pcWrEn, linkEn, aluFlagsEn, psrWrEn, psrWrSaved;
    logic        psrWrFlags, psrWrCtrl, irqReq, fiqReq, memReq, memByte, dataAbort;
    logic        xferIsSingle, excGo, excEn, irqTake, fiqTake, alignFault;
    logic        abortRollback, lateBaseWb, progSpaceWide, dataSpaceWide;
    int          nFail = 0;
    int          nCompared = 0;
    localparam logic [4:0] MC [0:4] = '{brf_pkg::MODE_FIQ, brf_pkg::MODE_SVC,
        brf_pkg::MODE_ABT, brf_pkg::MODE_IRQ, brf_pkg::MODE_UND};

    always #5 clk = ~clk;

    brf_regfile u_brf_regfile (.clk(clk), .sys_rst(sysRst), .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgRdData(cfgRdData),
        .rdSelA(rdSelA), .rdSelB(rdSelB), .rdDataA(rdDataA), .rdDataB(rdDataB),
        .wrEn(wrEn), .wrSel(wrSel), .wrData(wrData), .pcWrEn(pcWrEn), .pcNext(pcNext),
        .linkEn(linkEn), .aluFlagsEn(aluFlagsEn), .aluFlags(aluFlags), .psrWrEn(psrWrEn),
        .psrWrSaved(psrWrSaved), .psrWrFlags(psrWrFlags), .psrWrCtrl(psrWrCtrl),
        .psrWrData(psrWrData), .excEn(excEn), .excMode(excMode), .excLink(excLink),
        .irqReq(irqReq), .fiqReq(fiqReq), .irqTake(irqTake), .fiqTake(fiqTake),
        .curStatus(curStatus), .savedStatus(savedStatus), .memReq(memReq),
        .memByte(memByte), .memAddrLo(memAddrLo), .memStData(memStData),
        .memRdWord(memRdWord), .memWrWord(memWrWord), .memLaneEn(memLaneEn),
        .memLdData(memLdData), .alignFault(alignFault), .dataAbort(dataAbort),
        .xferIsSingle(xferIsSingle), .abortRollback(abortRollback),
        .lateBaseWb(lateBaseWb), .progSpaceWide(progSpaceWide),
        .dataSpaceWide(dataSpaceWide));

    brf_seq_model u_brf_seq_model (.clk(clk), .excGo(excGo), .excPick(excPick),
        .linkVal(linkVal), .memReq(memReq), .fillWord(fillWord), .excEn(excEn),
        .excMode(excMode), .excLink(excLink), .memRdWord(memRdWord));

    // ----------------------------------------------------------------
    // model helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lf = lf[0] ? ((lf >> 1) ^ 32'hA3000000) : (lf >> 1);
        return lf;
    endfunction
    // physical slot of visible register r in mode m
    function automatic int slot(input logic [4:0] m, input int r);
        if (r == 15) return 15;
        if (r >= 8 && m == brf_pkg::MODE_FIQ) return 8 + r;
        if (r < 13) return r;
        case (m)
            brf_pkg::MODE_SVC: return 10 + r;
            brf_pkg::MODE_ABT: return 12 + r;
            brf_pkg::MODE_IRQ: return 14 + r;
            brf_pkg::MODE_UND: return 16 + r;
            default:           return r;
        endcase
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrapUp();
        if (nFail == 0 && nCompared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // bus and datapath tasks, entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic rdReg(input int r);
        rdSelA <= r[3:0];
        rdSelB <= r[3:0];
        @(posedge clk);
        #1;
        chk(rdDataA, (r == 15) ? (pc & ~32'h3) : rm[slot(st[4:0], r)]);
        chk(rdDataB, (r == 15) ? (pc & ~32'h3) : rm[slot(st[4:0], r)]);
        @(posedge clk);
    endtask
    task automatic wrReg(input int r, input logic [31:0] v);
        wrEn <= 1'b1;
        wrSel <= r[3:0];
        wrData <= v;
        @(posedge clk);
        wrEn <= 1'b0;
        rm[slot(st[4:0], r)] = v;
    endtask
    task automatic pcw(input logic [31:0] v);
        pcWrEn <= 1'b1;
        pcNext <= v;
        @(posedge clk);
        pcWrEn <= 1'b0;
        pc = v;
    endtask
    task automatic cfgRd(input logic [3:0] a, input logic [31:0] exp);
        cfgRdEn <= 1'b1;
        cfgAddr <= a;
        @(posedge clk);
        cfgRdEn <= 1'b0;
        #1;
        chk(cfgRdData, exp);
        @(posedge clk);
    endtask
    task automatic cfgWr(input logic [3:0] v);
        cfgWrEn <= 1'b1;
        cfgAddr <= brf_pkg::ADDR_CFG;
        cfgWrData <= {28'h0000000, v};
        @(posedge clk);
        cfgWrEn <= 1'b0;
        cfg = v;
        #1;
        chk({30'h0, dataSpaceWide, progSpaceWide}, {30'h0, cfg[3:2]});
        @(posedge clk);
    endtask
    // ctrl writes only land in a privileged mode
    task automatic psrw(input logic fl, input logic ct, input logic [31:0] v);
        psrWrEn <= 1'b1;
        psrWrFlags <= fl;
        psrWrCtrl <= ct;
        psrWrData <= v;
        @(posedge clk);
        psrWrEn <= 1'b0;
        if (fl) st[31:28] = v[31:28];
        if (ct && st[4:0] != brf_pkg::MODE_USR) st[27:0] = v[27:0];
        #1;
        chk(curStatus, st);
        @(posedge clk);
    endtask
    task automatic exc(input int k);
        logic [31:0] lv;
        lv = rnd();
        excGo <= 1'b1;
        excPick <= k[2:0];
        linkVal <= lv;
        @(posedge clk);
        excGo <= 1'b0;
        sv[k] = st;
        st[4:0] = MC[k];
        st[7] = 1'b1;
        if (k == 0) st[6] = 1'b1;
        rm[slot(st[4:0], 14)] = lv;
        #1;
        chk(curStatus, st);
        @(posedge clk);
        #1;
        chk(savedStatus, sv[k]);
        @(posedge clk);
    endtask
    task automatic memOp(input logic byt, input int a, input logic ab, input logic sg);
        logic [31:0] fw;
        logic [31:0] sd;
        int          ln;
        fw = rnd();
        sd = rnd();
        ln = cfg[0] ? 3 - a : a;
        fillWord <= fw;
        memStData <= sd;
        memReq <= 1'b1;
        memByte <= byt;
        memAddrLo <= a[1:0];
        dataAbort <= ab;
        xferIsSingle <= sg;
        @(posedge clk);
        memReq <= 1'b0;
        dataAbort <= 1'b0;
        #1;
        chk({28'h0, memLaneEn}, byt ? (32'h1 << ln) : 32'hF);
        chk(memLdData, byt ? ((fw >> (8 * ln)) & 32'hFF) : fw);
        chk(memWrWord, byt ? {4{sd[7:0]}} : sd);
        chk({31'h0, alignFault}, {31'h0, !byt && a != 0});
        chk({30'h0, abortRollback, lateBaseWb}, {30'h0, ab & sg & ~cfg[1], ab & sg & cfg[1]});
        @(posedge clk);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {cfgWrEn, cfgRdEn, wrEn, pcWrEn, linkEn, aluFlagsEn, psrWrEn, psrWrSaved} = '0;
        {psrWrFlags, psrWrCtrl, irqReq, fiqReq, memReq, memByte, dataAbort} = '0;
        {xferIsSingle, excGo, excPick, memAddrLo, cfgAddr, rdSelA, rdSelB, wrSel} = '0;
        {aluFlags, cfgWrData, wrData, pcNext, psrWrData, memStData, fillWord, linkVal} = '0;
        repeat (4) @(posedge clk);
        sysRst <= 1'b0;
        st = brf_pkg::PSR_RESET;
        cfg = brf_pkg::CFG_RESET;
        pc = 32'h0;
        repeat (2) @(posedge clk);
        cfgRd(brf_pkg::ADDR_CFG, {28'h0000000, cfg});
        cfgRd(brf_pkg::ADDR_STATUS, st);
        cfgRd(4'hC, 32'h0);
        pcw(rnd() | 32'h3);
        rdReg(15);
        // second pass proves no bank leaks into another mode
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 5; k++) begin
                exc(k);
                cfgRd(brf_pkg::ADDR_SAVED, sv[k]);
                for (int r = 8; r < 15; r++) begin
                    if (p == 0) wrReg(r, rnd());
                    rdReg(r);
                end
            end
        end
        pcw(rnd() & ~32'h3);
        linkEn <= 1'b1;
        @(posedge clk);
        linkEn <= 1'b0;
        rm[slot(st[4:0], 14)] = pc;
        rdReg(14);
        irqReq <= 1'b1;
        fiqReq <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            d = st;
            d[7:6] = k[1:0];
            psrw(1'b0, 1'b1, d);
            #1;
            chk({30'h0, irqTake, fiqTake}, {30'h0, ~d[7], ~d[6]});
            @(posedge clk);
        end
        d = rnd();
        aluFlagsEn <= 1'b1;
        aluFlags <= d[3:0];
        @(posedge clk);
        aluFlagsEn <= 1'b0;
        st[31:28] = d[3:0];
        #1;
        chk(curStatus, st);
        @(posedge clk);
        d = st;
        d[4:0] = brf_pkg::MODE_USR;
        psrw(1'b1, 1'b1, d);
        wrReg(13, rnd());
        rdReg(13);
        rdReg(8);
        cfgRd(brf_pkg::ADDR_SAVED, 32'h0);
        chk(savedStatus, 32'h0);
        d = st;
        d[31:28] = ~st[31:28];
        d[4:0] = brf_pkg::MODE_SVC;
        d[7:6] = 2'b00;
        psrw(1'b1, 1'b1, d);
        exc(1);
        {psrWrEn, psrWrSaved, psrWrFlags, psrWrCtrl} <= 4'hF;
        psrWrData <= ~st;
        @(posedge clk);
        psrWrEn <= 1'b0;
        cfgRd(brf_pkg::ADDR_SAVED, ~st);
        for (int b = 0; b < 4; b++) begin
            cfgWr({2'b11, b[1:0]});
            for (int a = 0; a < 4; a++) begin
                memOp(1'b1, a, a[0], a[1]);
                memOp(1'b0, a, 1'b1, 1'b1);
            end
        end
        wrapUp();
    end

    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        wrapUp();
    end
endmodule
